// >>> core/synth_ctl_pkg.sv
// Constants and types for the synthesizer serial write-control block.
// Assumes one 40 MHz clock that samples the bus pins directly.
`default_nettype none

package synth_ctl_pkg;

    // Clock rate of mclk_i
    localparam int CLK_HZ = 40_000_000;

    // Bus addresses, upper seven bits; bit 0 is the direction bit
    localparam logic [6:0] ADDR_FIXED = 7'h61; // 194 decimal, always valid
    localparam logic [6:0] ADDR_LOW = 7'h60; // 192 decimal
    localparam logic [6:0] ADDR_MID = 7'h62; // 196 decimal
    localparam logic [6:0] ADDR_HIGH = 7'h63; // 198 decimal
    localparam int ADDR_RW_BIT = 0;
    localparam logic DIR_WRITE = 1'b0;

    // Levels reported on addr_select_input
    localparam logic [1:0] SEL_LOW = 2'h0;
    localparam logic [1:0] SEL_MID = 2'h1;
    localparam logic [1:0] SEL_HIGH = 2'h2;

    // Bit counter marks
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;

    // Data byte fields
    localparam int KIND_BIT = 7;
    localparam int PORT_MSB = 7;
    localparam int PORT_LSB = 3;
    localparam int PORT_W = 5;
    localparam int PIN_DIV_OUT = 4; // Port seven carries divider output
    localparam int PIN_REF_OUT = 3; // Port six carries reference output

    // Reference divider ratios
    localparam logic [10:0] REF_RATIO_640 = 11'h280;
    localparam logic [10:0] REF_RATIO_1024 = 11'h400;
    localparam logic [10:0] REF_RATIO_512 = 11'h200;

    // Control latch, laid out as bits 6..0 of the control byte
    typedef struct packed {
        logic pump_current_high;
        logic divider_test_enable;
        logic pump_disable;
        logic prescaler_enable;
        logic refdiv_select_high;
        logic refdiv_select_low;
        logic tuning_drive_disable;
    } ctrl_s;

    // Reset values of the latches
    localparam logic [6:0] CTRL_RST = 7'h08; // Prescaler in path
    localparam logic [PORT_W-1:0] PORT_RST = 5'h00; // All ports off
    localparam logic [6:0] DIVHI_RST = 7'h00;
    localparam logic [7:0] DIVLO_RST = 8'h00;

    // Serial engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ADDR = 3'b010,
        ST_DATA = 3'b100
    } bus_state_e;

    // Expected kind of the next data byte
    typedef enum logic [2:0] {
        BK_FIRST = 3'b001,
        BK_DIVLO = 3'b010,
        BK_PORT = 3'b100
    } byte_kind_e;

    // Reference ratio from the two select bits
    function automatic logic [10:0] ref_ratio(input logic hi,
                                              input logic lo);
        if (!lo)
            return REF_RATIO_640;
        else if (!hi)
            return REF_RATIO_1024;
        else
            return REF_RATIO_512;
    endfunction : ref_ratio

endpackage : synth_ctl_pkg

`default_nettype wire

// >>> core/synth_ctl_write.sv
// Serial write-control target of the frequency synthesizer.
// Assumes SCL/SDA synchronous to mclk_i and oversampled several times.
//
// Functional notes
// [R1] Address bit 0 low means write; high means read.
// [R2] Answer the fixed address and one address picked by the select input.
// [R3] Pull SDA low in the acknowledge slot after address and each data byte.
// [R4] Controller sends two divider bytes and two control/port bytes.
// [R5] First data byte: leading 0 is divider high, leading 1 is control.
// [R6] Divider high is followed by divider low; control by port byte.
// [R7] Further bytes keep being decoded without re-addressing until stop.
// [R8] Two divider bytes form 15-bit ratio, latched at eighth pulse.
// [R9] Control and port latches load at eighth pulse of their byte.
// [R10] Current-select bit switches pump between low and high current.
// [R11] Divider-test bit high enters divider test mode.
// [R12] Pump-disable bit high disables the charge pump output.
// [R13] Prescaler bit low bypasses the prescaler; high keeps it.
// [R14] Tuning-drive-disable bit high turns off the drive amplifier.
// [R15] Two select bits choose the reference divider ratio.
// [R16] Three-wire control forces high pump current.
// [R17] Port bit 0 releases its open-collector output; 1 pulls it low.
// [R18] Power-on reset clears all port latches, outputs released.
// [R19] Low select 0 gives 640; 01 gives 1024; 11 gives 512.
// [R20] Test mode puts divider outputs on two port pins.
// [R21] Fixed 194 always; 192, 196 or 198 by select input level.
// [R22] Unmatched address: stay off SDA until next start; stop idles.
`timescale 1ns/1ps
`default_nettype none

module synth_ctl_write
    import synth_ctl_pkg::*;
#(
    parameter int DIV_W = 15
)(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [1:0] addr_select_input_i,
    input wire logic three_wire_mode_i,
    input wire logic prog_divider_output_i,
    input wire logic ref_divider_output_i,
    output logic [DIV_W-1:0] divider_ratio_o,
    output logic pump_current_high_o,
    output logic divider_test_enable_o,
    output logic pump_disable_o,
    output logic prescaler_enable_o,
    output logic refdiv_select_low_o,
    output logic refdiv_select_high_o,
    output logic tuning_drive_disable_o,
    output logic [10:0] ref_divide_ratio_o,
    output logic [PORT_W-1:0] port_o,
    output logic [PORT_W-1:0] port_oe_o
);

    // Refuse widths the byte layout cannot serve
    if (DIV_W != 15)
    begin : g_bad_width
        $error("DIV_W must be 15");
    end

    // Serial engine state
    bus_state_e state_r;
    byte_kind_e kind_r;
    logic [3:0] cnt_r;
    logic [7:0] shift_r;
    logic scl_q_r;
    logic sda_q_r;
    logic ack_ok_r;
    logic drive_r;

    // Latches
    logic [6:0] divhi_r;
    logic [DIV_W-1:0] ratio_r;
    ctrl_s ctrl_r;
    logic [PORT_W-1:0] port_r;

    // Bus event decode
    wire scl_rise = scl_i & ~scl_q_r;
    wire scl_fall = ~scl_i & scl_q_r;
    wire start_det = scl_i & scl_q_r & sda_q_r & ~sda_i;
    wire stop_det = scl_i & scl_q_r & ~sda_q_r & sda_i;
    wire active = (state_r == ST_ADDR) || (state_r == ST_DATA);
    wire bit_clk = scl_rise & active & (cnt_r < ACK_SLOT);
    wire byte_done = bit_clk & (cnt_r == BIT_LAST);
    wire ack_clk = scl_rise & active & (cnt_r == ACK_SLOT);
    wire [7:0] byte_in = {shift_r[6:0], sda_i};

    // Address matching
    wire [6:0] prog_addr = (addr_select_input_i == SEL_LOW) ? ADDR_LOW :
                           (addr_select_input_i == SEL_MID) ? ADDR_MID :
                           ADDR_HIGH; // see [R21]
    wire sel_valid = (addr_select_input_i == SEL_LOW) ||
                     (addr_select_input_i == SEL_MID) ||
                     (addr_select_input_i == SEL_HIGH);
    wire addr_hit = (byte_in[7:1] == ADDR_FIXED) ||
                    (sel_valid && byte_in[7:1] == prog_addr); // see [R2]
    wire is_write = (byte_in[ADDR_RW_BIT] == DIR_WRITE); // see [R1]
    wire addr_done = byte_done & (state_r == ST_ADDR);
    wire addr_take = addr_done & addr_hit & is_write;

    // Data byte classification
    wire data_done = byte_done & (state_r == ST_DATA);
    wire first_div = (kind_r == BK_FIRST) & ~byte_in[KIND_BIT]; // see [R5]
    wire first_ctl = (kind_r == BK_FIRST) & byte_in[KIND_BIT]; // see [R5]
    wire load_divlo = data_done & (kind_r == BK_DIVLO);
    wire load_ctrl = data_done & first_ctl;
    wire load_port = data_done & (kind_r == BK_PORT);
    wire load_divhi = data_done & first_div;

    // Next kind of byte expected
    byte_kind_e kind_nxt;
    assign kind_nxt = first_div ? BK_DIVLO : // see [R6]
                      first_ctl ? BK_PORT : // see [R6]
                      BK_FIRST; // see [R7]

    // Pin sampling history
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end
        else
        begin
            scl_q_r <= scl_i;
            sda_q_r <= sda_i;
        end
    end

    // Framing: start, stop, address, data phases
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            state_r <= ST_IDLE;
        else if (start_det)
            state_r <= ST_ADDR;
        else if (stop_det)
            state_r <= ST_IDLE; // see [R22]
        else if (addr_done)
            state_r <= addr_take ? ST_DATA : ST_IDLE; // see [R22]
    end

    // Bit counter and shifter
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
        end
        else if (start_det)
            cnt_r <= 4'h0;
        else if (bit_clk)
        begin
            cnt_r <= cnt_r + 4'h1;
            shift_r <= byte_in;
        end
        else if (ack_clk)
            cnt_r <= 4'h0;
    end

    // Acknowledge decision and SDA drive
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ack_ok_r <= 1'b0;
            drive_r <= 1'b0;
        end
        else if (start_det || stop_det)
        begin
            ack_ok_r <= 1'b0;
            drive_r <= 1'b0;
        end
        else
        begin
            if (byte_done)
                ack_ok_r <= addr_take | (state_r == ST_DATA); // see [R3]
            if (scl_fall && cnt_r == ACK_SLOT)
                drive_r <= ack_ok_r; // see [R3]
            else if (scl_fall)
                drive_r <= 1'b0;
        end
    end

    // Byte kind tracking across a transfer
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            kind_r <= BK_FIRST;
        else if (start_det)
            kind_r <= BK_FIRST;
        else if (data_done)
            kind_r <= kind_nxt;
    end

    // Divider latches: high byte held at its own eighth pulse, ratio loaded on the eighth pulse of the low byte
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            divhi_r <= DIVHI_RST;
            ratio_r <= {DIVHI_RST, DIVLO_RST};
        end
        else
        begin
            if (load_divhi)
                divhi_r <= byte_in[6:0];
            if (load_divlo)
                ratio_r <= {divhi_r, byte_in}; // see [R8]
        end
    end

    // Control and port latches; reset releases all ports
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl_r <= ctrl_s'(CTRL_RST);
            port_r <= PORT_RST; // see [R18]
        end
        else
        begin
            if (load_ctrl)
                ctrl_r <= ctrl_s'(byte_in[6:0]); // see [R9]
            if (load_port)
                port_r <= byte_in[PORT_MSB:PORT_LSB]; // see [R9]
        end
    end

    // Open-drain SDA
    assign sda_o = 1'b0;
    assign sda_oe_o = drive_r; // see [R3]

    // Control outputs
    assign divider_ratio_o = ratio_r;
    assign pump_current_high_o = ctrl_r.pump_current_high |
                                 three_wire_mode_i; // see [R10] [R16]
    assign divider_test_enable_o = ctrl_r.divider_test_enable; // see [R11]
    assign pump_disable_o = ctrl_r.pump_disable; // see [R12]
    assign prescaler_enable_o = ctrl_r.prescaler_enable; // see [R13]
    assign tuning_drive_disable_o = ctrl_r.tuning_drive_disable; // see [R14]
    assign refdiv_select_low_o = ctrl_r.refdiv_select_low; // see [R15]
    assign refdiv_select_high_o = ctrl_r.refdiv_select_high; // see [R15]
    assign ref_divide_ratio_o = ref_ratio(ctrl_r.refdiv_select_high,
                                          ctrl_r.refdiv_select_low); // see [R19]

    // Port pins; test mode routes divider outputs to ports seven and six
    logic [PORT_W-1:0] test_oe;
    always_comb
    begin
        test_oe = port_r; // see [R17]
        test_oe[PIN_DIV_OUT] = ~prog_divider_output_i;
        test_oe[PIN_REF_OUT] = ~ref_divider_output_i;
    end
    assign port_o = {PORT_W{1'b0}};
    assign port_oe_o = ctrl_r.divider_test_enable ? test_oe : port_r; // see [R20]

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_addr_hit;
        addr_take;
    endsequence

    sequence s_ack_fall;
        scl_fall && cnt_r == ACK_SLOT;
    endsequence

    // Engine armed to pull SDA in the coming acknowledge slot
    sequence s_ack_armed;
        ack_ok_r && state_r == ST_DATA;
    endsequence

    a_ack_after_addr: assert property ( // see [R3]
        s_addr_hit |=> s_ack_armed)
    else $error("address acknowledge missing");

    a_data_ack_drive: assert property ( // see [R3]
        s_ack_armed ##0 s_ack_fall |=> sda_oe_o)
    else $error("data byte not acknowledged");

    a_ignore_quiet: assert property ( // see [R22]
        state_r == ST_IDLE && !drive_r |=> !sda_oe_o)
    else $error("SDA driven while not addressed");

    a_stop_idles: assert property ( // see [R22]
        stop_det && !start_det |=> state_r == ST_IDLE && !sda_oe_o)
    else $error("stop did not idle the decoder");

    a_read_refused: assert property ( // see [R1]
        addr_done && !is_write && !start_det && !stop_det
        |=> state_r == ST_IDLE)
    else $error("read address taken as write");

    a_divider_latch: assert property ( // see [R8]
        load_divlo && !start_det && !stop_det
        |=> divider_ratio_o == {$past(divhi_r), $past(byte_in)})
    else $error("divider latch wrong");

    a_ctrl_latch: assert property ( // see [R9] [R12]
        load_ctrl |=> pump_disable_o == $past(byte_in[4]) &&
        prescaler_enable_o == $past(byte_in[3]))
    else $error("control latch wrong");

    a_kind_order: assert property ( // see [R5] [R6]
        data_done && first_div && !start_det |=> kind_r == BK_DIVLO)
    else $error("divider byte order lost");

    a_port_latch: assert property ( // see [R17]
        load_port && !ctrl_r.divider_test_enable && !start_det
        |=> port_oe_o == $past(byte_in[PORT_MSB:PORT_LSB]))
    else $error("port latch wrong");

    a_three_wire_high: assert property ( // see [R16]
        three_wire_mode_i |-> pump_current_high_o)
    else $error("three-wire mode lost high current");

    a_refdiv_code: assert property ( // see [R19]
        !refdiv_select_low_o |-> ref_divide_ratio_o == REF_RATIO_640)
    else $error("reference ratio wrong");

    a_test_pins: assert property ( // see [R20]
        divider_test_enable_o |->
        port_oe_o[PIN_DIV_OUT] == !prog_divider_output_i)
    else $error("test mode pin routing wrong");

endmodule : synth_ctl_write

`default_nettype wire

// >>> verif/bus_ctrl_model.sv
// Behavioural bus controller that writes to the synthesizer target.
// Assumes the bench resolves SDA from both pulls with a pull-up.
`timescale 1ns/1ps
`default_nettype none

module bus_ctrl_model (
    input wire logic mclk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // Bus released; the clock stands high outside frames
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    // Quarter bit period; all changes land on falling mclk edges
    task automatic quarter();
        repeat (2) @(negedge mclk_i);
    endtask : quarter

    // Start, also usable as a repeated start
    task automatic start();
        quarter();
        sda_low_o = 1'b0;
        quarter();
        scl_o = 1'b1;
        quarter();
        quarter();
        sda_low_o = 1'b1;
        quarter();
        quarter();
        scl_o = 1'b0;
    endtask : start

    // Byte MSB first, then SDA released and the answer read in SCL high
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= -1; i--)
        begin
            quarter();
            sda_low_o = (i >= 0) ? ~b[i & 7] : 1'b0;
            quarter();
            scl_o = 1'b1;
            quarter();
            quarter();
            ack = ~sda_i;
            scl_o = 1'b0;
        end
    endtask : send

    // Stop: SDA rises while SCL is high, then the bus rests
    task automatic stop();
        quarter();
        sda_low_o = 1'b1;
        quarter();
        scl_o = 1'b1;
        quarter();
        quarter();
        sda_low_o = 1'b0;
        quarter();
        quarter();
    endtask : stop
endmodule : bus_ctrl_model

`default_nettype wire

// >>> verif/pll_synth_i2c_write_control_bench.sv
// Self-checking bench for the synthesizer serial write-control block.
// Assumes bus_ctrl_model as bus controller and SDA pulled up.
`timescale 1ns/1ps
`default_nettype none

module pll_synth_i2c_write_control_bench;
    import synth_ctl_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] sel = 2'h3;
    logic tw = 1'b0;
    logic pdo = 1'b0;
    logic rdo = 1'b0;
    logic scl, sda_low, sdo, oe, ack;
    logic [14:0] ratio;
    logic [10:0] rr;
    logic [4:0] port, poe;
    wire logic sda;
    wire logic [6:0] ctl;
    int n_fail = 0;
    int checks = 0;

    // Clock and the resolved open-drain data line
    always #12.5 mclk = ~mclk;
    assign sda = ~sda_low & (~oe | sdo);

    synth_ctl_write synth_ctl_write_inst (
        .mclk_i(mclk), .rst_i(rst), .scl_i(scl), .sda_i(sda),
        .sda_o(sdo), .sda_oe_o(oe), .addr_select_input_i(sel),
        .three_wire_mode_i(tw), .prog_divider_output_i(pdo),
        .ref_divider_output_i(rdo), .divider_ratio_o(ratio),
        .pump_current_high_o(ctl[6]), .divider_test_enable_o(ctl[5]),
        .pump_disable_o(ctl[4]), .prescaler_enable_o(ctl[3]),
        .refdiv_select_high_o(ctl[2]), .refdiv_select_low_o(ctl[1]),
        .tuning_drive_disable_o(ctl[0]), .ref_divide_ratio_o(rr),
        .port_o(port), .port_oe_o(poe)
    );

    bus_ctrl_model bus_ctrl_model_inst (
        .mclk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low)
    );

    // Compare tasks, one per kind of result
    task automatic chk_bit(input string n, input logic e, input logic g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit

    task automatic chk_val(input string n, input logic [15:0] e,
                           input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk_val

    // One byte on the bus with its expected acknowledge
    task automatic put(input logic [7:0] b, input logic e);
        bus_ctrl_model_inst.send(b, ack);
        chk_bit("ack", e, ack);
    endtask : put

    // Values right after power-on reset
    task automatic t_reset();
        chk_val("port_oe", 16'h0000, 16'(poe));
        chk_val("port", 16'h0000, 16'(port));
        chk_val("ctrl", 16'(CTRL_RST), 16'(ctl));
        chk_val("ratio", 16'h0000, 16'(ratio));
        chk_val("refdiv", 16'h0280, 16'(rr));
        chk_bit("sda_oe", 1'b0, oe);
    endtask : t_reset

    // Divider pairs back to back, then a lone high byte before stop
    task automatic t_divider();
        bus_ctrl_model_inst.start();
        put(8'hC2, 1'b1);
        put(8'h55, 1'b1);
        chk_val("ratio", 16'h0000, 16'(ratio));
        put(8'hAA, 1'b1);
        chk_val("ratio", 16'h55AA, 16'(ratio));
        put(8'h7F, 1'b1);
        put(8'h01, 1'b1);
        chk_val("ratio", 16'h7F01, 16'(ratio));
        put(8'h12, 1'b1);
        bus_ctrl_model_inst.stop();
        chk_val("ratio", 16'h7F01, 16'(ratio));
    endtask : t_divider

    // Control and port bytes over a table, incl. test and three-wire mode
    task automatic t_control();
        logic [6:0] ct [4] = '{7'h00, 7'h43, 7'h3E, 7'h75};
        logic [4:0] pt [4] = '{5'h1F, 5'h0A, 5'h15, 5'h00};
        logic [6:0] ec;
        logic [4:0] ep;
        logic [10:0] er;
        for (int i = 0; i < 4; i++)
        begin
            @(negedge mclk);
            tw = (i == 2);
            pdo = i[0];
            rdo = ~i[0];
            bus_ctrl_model_inst.start();
            put(8'hC2, 1'b1);
            put({1'b1, ct[i]}, 1'b1);
            ec = ct[i] | {tw, 6'h00};
            chk_val("ctrl", 16'(ec), 16'(ctl));
            er = ct[i][2] ? REF_RATIO_512 : REF_RATIO_1024;
            er = ct[i][1] ? er : REF_RATIO_640;
            chk_val("refdiv", 16'(er), 16'(rr));
            put({pt[i], 3'h0}, 1'b1);
            ep = ct[i][5] ? {~pdo, ~rdo, pt[i][2:0]} : pt[i];
            chk_val("port_oe", 16'(ep), 16'(poe));
            bus_ctrl_model_inst.stop();
        end
    endtask : t_control

    // Every address under every select level, then a read request
    task automatic t_addr();
        logic m;
        logic [14:0] ex;
        ex = 15'h7F01;
        for (int s = 0; s < 4; s++)
        begin
            @(negedge mclk);
            sel = 2'(s);
            for (int a = 0; a < 4; a++)
            begin
                m = (a == 1) || (s == 0 && a == 0);
                m = m || (s == 1 && a == 2) || (s == 2 && a == 3);
                ex = m ? {7'(s * 4 + a), 8'hC3} : ex;
                bus_ctrl_model_inst.start();
                put({7'h60 + 7'(a), DIR_WRITE}, m);
                put({1'b0, 7'(s * 4 + a)}, m);
                put(8'hC3, m);
                bus_ctrl_model_inst.stop();
                chk_val("ratio", 16'(ex), 16'(ratio));
            end
        end
        bus_ctrl_model_inst.start();
        put(8'hC3, 1'b0);
        put(8'h00, 1'b0);
        bus_ctrl_model_inst.stop();
        chk_val("ratio", 16'(ex), 16'(ratio));
    endtask : t_addr

    // Reset in mid-run with ports on: all released, latches back to reset
    task automatic t_por();
        bus_ctrl_model_inst.start();
        put(8'hC2, 1'b1);
        put(8'h80, 1'b1);
        put(8'hF8, 1'b1);
        chk_val("port_oe", 16'h001F, 16'(poe));
        bus_ctrl_model_inst.stop();
        @(negedge mclk);
        rst = 1'b1;
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        chk_val("port_oe", 16'h0000, 16'(poe));
        chk_val("ctrl", 16'(CTRL_RST), 16'(ctl));
        chk_val("ratio", 16'h0000, 16'(ratio));
        chk_bit("sda_oe", 1'b0, oe);
    endtask : t_por

    // Verdict and end of run
    task automatic end_of_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    // Main sequence after a 20-cycle reset
    initial
    begin
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        t_reset();
        t_divider();
        t_control();
        t_addr();
        t_por();
        end_of_test();
    end

    // Watchdog well beyond the expected run of about 5700 cycles
    initial
    begin
        repeat (60000) @(posedge mclk);
        n_fail++;
        end_of_test();
    end
endmodule : pll_synth_i2c_write_control_bench

`default_nettype wire
